// File: cms_pkg.sv
// Package: register map, modes, fields and timing constants for the modulation sequencer
package cms_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned AW              = 8;
    // Byte offsets of the registers
    localparam logic [7:0] OFF_CTRL         = 8'h00;
    localparam logic [7:0] OFF_CW_FREQ      = 8'h04;
    localparam logic [7:0] OFF_AMPL         = 8'h08;
    localparam logic [7:0] OFF_DWELL        = 8'h0c;
    localparam logic [7:0] OFF_HOP_LEN      = 8'h10;
    localparam logic [7:0] OFF_HOP_MARK     = 8'h14;
    localparam logic [7:0] OFF_SW_START     = 8'h18;
    localparam logic [7:0] OFF_SW_STOP      = 8'h1c;
    localparam logic [7:0] OFF_SW_TIME      = 8'h20;
    localparam logic [7:0] OFF_SW_MARK      = 8'h24;
    localparam logic [7:0] OFF_CH_PRI       = 8'h28;
    localparam logic [7:0] OFF_AM_DEPTH     = 8'h2c;
    localparam logic [7:0] OFF_AM_FREQ      = 8'h30;
    localparam logic [7:0] OFF_STATUS       = 8'h34;
    localparam logic [7:0] OFF_HOP_IDX      = 8'h38;
    localparam logic [7:0] OFF_HOP_FREQ     = 8'h3c;
    localparam logic [7:0] OFF_HOP_DWELL    = 8'h40;
    // Control register field positions
    localparam int unsigned CTRL_MODE_LSB   = 0;
    localparam int unsigned CTRL_SHAPE_LSB  = 4;
    localparam int unsigned CTRL_ENV_LSB    = 6;
    localparam int unsigned CTRL_DWELL_VAR  = 8;
    localparam int unsigned CTRL_SW_LOG     = 9;
    localparam int unsigned CTRL_SW_DOWN    = 10;
    localparam int unsigned CTRL_AM_LOG     = 11;
    localparam int unsigned CTRL_AM_DOWN    = 12;
    // Reset values
    localparam logic [31:0] RST_CTRL        = 32'h0000_0000;
    localparam logic [31:0] RST_DWELL       = 32'h0000_0064;
    localparam logic [31:0] RST_TIME        = 32'h0000_03e8;
    localparam logic [31:0] RST_AMPL        = 32'h0000_ffff;
    // Percent limits of the depth settings
    localparam logic [7:0] CHIRP_DEPTH_MAX  = 8'h64;
    localparam logic [7:0] AM_DEPTH_MAX     = 8'hc8;
    // Envelope frequency limits in Hz
    localparam int unsigned AM_FMIN_HZ      = 100;
    localparam int unsigned AM_FMAX_HZ      = 1000000;
    // Phase increment of the envelope per Hz at 32-bit accumulator: 2^32 / CLK_HZ
    localparam int unsigned ENV_K_NUM       = 32'hd6bf;   // ~ 2^32/20e6 * 256
    localparam int unsigned ENV_K_SHIFT     = 8;

    typedef enum logic [3:0] {
        MOD_OFF   = 4'b0000,
        MOD_FM    = 4'b0001,
        MOD_FSK   = 4'b0010,
        MOD_FHOP  = 4'b0011,
        MOD_SWEEP = 4'b0100,
        MOD_CHIRP = 4'b0101,
        MOD_AM    = 4'b0110,
        MOD_ASK   = 4'b0111,
        MOD_AHOP  = 4'b1000
    } cms_mode_t;

    typedef enum logic [1:0] {
        SHP_SINE = 2'b00,
        SHP_TRI  = 2'b01,
        SHP_SQR  = 2'b10,
        SHP_RAMP = 2'b11
    } cms_shape_t;

    // Synthesis command toward the waveform datapath
    typedef struct packed {
        logic [47:0] freq;
        logic [15:0] ampl;
        logic [1:0]  carrier_shape;
        logic [3:0]  mode;
    } cms_synth_t;
endpackage

// File: cms_sequencer.sv
// Modulation sequencer: hop, sweep, chirp and AM control with a Wishbone slave
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module cms_sequencer #(
    parameter int unsigned HOP_DEPTH = 64,
    parameter int unsigned HW        = 6
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output cms_pkg::cms_synth_t    synth_o,
    output logic                   sync_o
);
    if (HOP_DEPTH < 2 || HOP_DEPTH > (1 << HW) || HW > 16) begin : g_bad_geom
        $error("cms_sequencer: bad hop table geometry");
    end

    // Configuration registers
    logic [31:0] ctrl_r, cw_freq_r, ampl_r, dwell_r, sw_start_r, sw_stop_r;
    logic [31:0] sw_time_r, sw_mark_r, ch_pri_r, am_freq_r;
    logic [HW-1:0] hop_len_r, hop_mark_r, tbl_idx_r;
    logic [7:0]  am_depth_r;
    logic [47:0] hop_freq_mem [HOP_DEPTH];
    logic [31:0] hop_dwell_mem [HOP_DEPTH];
    logic [15:0] tbl_hi_r;

    cms_pkg::cms_mode_t mode;
    assign mode = cms_pkg::cms_mode_t'(ctrl_r[cms_pkg::CTRL_MODE_LSB +: 4]);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) m[8*i +: 8] = d[8*i +: 8];
        end
        return m;
    endfunction

    logic req, wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i && ce_i;

    // Register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r     <= cms_pkg::RST_CTRL;
            cw_freq_r  <= '0;
            ampl_r     <= cms_pkg::RST_AMPL;
            dwell_r    <= cms_pkg::RST_DWELL;
            hop_len_r  <= HW'(HOP_DEPTH - 1);
            hop_mark_r <= '0;
            sw_start_r <= '0;
            sw_stop_r  <= '0;
            sw_time_r  <= cms_pkg::RST_TIME;
            sw_mark_r  <= '0;
            ch_pri_r   <= cms_pkg::RST_TIME;
            am_depth_r <= '0;
            am_freq_r  <= 32'(cms_pkg::AM_FMIN_HZ);
            tbl_idx_r  <= '0;
            tbl_hi_r   <= '0;
        end else if (wr) begin
            unique case (wb_adr_i)
                cms_pkg::OFF_CTRL:     ctrl_r     <= merge(ctrl_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_CW_FREQ:  cw_freq_r  <= merge(cw_freq_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_AMPL:     ampl_r     <= merge(ampl_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_DWELL:    dwell_r    <= merge(dwell_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_HOP_LEN:  hop_len_r  <= wb_dat_i[HW-1:0];
                cms_pkg::OFF_HOP_MARK: hop_mark_r <= wb_dat_i[HW-1:0];
                cms_pkg::OFF_SW_START: sw_start_r <= merge(sw_start_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_SW_STOP:  sw_stop_r  <= merge(sw_stop_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_SW_TIME:  sw_time_r  <= merge(sw_time_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_SW_MARK:  sw_mark_r  <= merge(sw_mark_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_CH_PRI:   ch_pri_r   <= merge(ch_pri_r, wb_dat_i, wb_sel_i);
                cms_pkg::OFF_AM_DEPTH: begin
                    // Clamp to 200%
                    am_depth_r <= (wb_dat_i[7:0] > cms_pkg::AM_DEPTH_MAX) ?
                                  cms_pkg::AM_DEPTH_MAX : wb_dat_i[7:0];
                end
                cms_pkg::OFF_AM_FREQ: begin
                    // Clamp to 100 Hz .. 1 MHz
                    if (wb_dat_i < 32'(cms_pkg::AM_FMIN_HZ)) am_freq_r <= 32'(cms_pkg::AM_FMIN_HZ);
                    else if (wb_dat_i > 32'(cms_pkg::AM_FMAX_HZ))
                        am_freq_r <= 32'(cms_pkg::AM_FMAX_HZ);
                    else am_freq_r <= wb_dat_i;
                end
                cms_pkg::OFF_HOP_IDX: begin
                    tbl_idx_r <= wb_dat_i[HW-1:0];
                    tbl_hi_r  <= wb_dat_i[31:16];
                end
                default: ;
            endcase
        end
    end

    // Hop table: upper 16 frequency bits staged through index register
    always_ff @(posedge clk_i) begin
        if (wr && wb_adr_i == cms_pkg::OFF_HOP_FREQ && 32'(tbl_idx_r) < HOP_DEPTH) begin
            hop_freq_mem[tbl_idx_r] <= {tbl_hi_r, wb_dat_i};
        end
        if (wr && wb_adr_i == cms_pkg::OFF_HOP_DWELL && 32'(tbl_idx_r) < HOP_DEPTH) begin
            hop_dwell_mem[tbl_idx_r] <= wb_dat_i;
        end
    end

    // Hop sequencer
    logic [HW-1:0] hop_pos_r;
    logic [31:0]   hop_cnt_r, hop_dwell_cur;
    logic          hop_end;
    assign hop_dwell_cur = ctrl_r[cms_pkg::CTRL_DWELL_VAR] ?
                           hop_dwell_mem[hop_pos_r] : dwell_r;
    assign hop_end = hop_cnt_r + 32'h1 >= hop_dwell_cur;
    always_ff @(posedge clk_i) begin
        if (rst_i || mode != cms_pkg::MOD_FHOP) begin
            hop_pos_r <= '0;
            hop_cnt_r <= '0;
        end else if (ce_i) begin
            if (hop_end) begin
                hop_cnt_r <= '0;
                hop_pos_r <= (hop_pos_r >= hop_len_r) ? '0 : hop_pos_r + 1'b1;
            end else begin
                hop_cnt_r <= hop_cnt_r + 32'h1;
            end
        end
    end

    // Sweep and chirp time base
    logic [31:0] t_r, per_r;
    logic [31:0] sw_len, per_nxt;
    logic        sweeping;
    assign sweeping = mode == cms_pkg::MOD_SWEEP || mode == cms_pkg::MOD_CHIRP;
    assign sw_len = sw_time_r;
    assign per_nxt = (per_r + 32'h1 >= ch_pri_r) ? 32'h0 : per_r + 32'h1;
    always_ff @(posedge clk_i) begin
        if (rst_i || !sweeping) begin
            t_r   <= '0;
            per_r <= '0;
        end else if (ce_i) begin
            if (mode == cms_pkg::MOD_CHIRP) begin
                // Width in sw_time, repetition in ch_pri
                // Sweep position follows the period counter, held after the width
                per_r <= per_nxt;
                t_r   <= (per_nxt < sw_time_r) ? per_nxt : t_r;
            end else begin
                per_r <= '0;
                t_r <= (t_r + 32'h1 >= sw_time_r) ? '0 : t_r + 32'h1;
            end
        end
    end

    // Fraction of the sweep elapsed, 16-bit
    logic [15:0] frac;
    logic [47:0] frac_w;
    assign frac_w = ({16'h0, t_r} << 16) / {16'h0, (sw_time_r == 0 ? 32'h1 : sw_time_r)};
    assign frac = frac_w[15:0];

    // Log shaping: fraction squared approximates exponential spread
    function automatic logic [15:0] shape_step(input logic [15:0] f, input logic lg);
        logic [31:0] sq;
        sq = f * f;
        return lg ? sq[31:16] : f;
    endfunction

    logic [31:0] f_lo, f_hi, f_now;
    logic [15:0] fs;
    logic [47:0] span_mul;
    assign f_lo = ctrl_r[cms_pkg::CTRL_SW_DOWN] ? sw_stop_r : sw_start_r;
    assign f_hi = ctrl_r[cms_pkg::CTRL_SW_DOWN] ? sw_start_r : sw_stop_r;
    assign fs   = shape_step(frac, ctrl_r[cms_pkg::CTRL_SW_LOG]);
    assign span_mul = ($signed({16'h0, f_hi}) - $signed({16'h0, f_lo})) * $signed({32'h0, fs});
    assign f_now = f_lo + span_mul[47:16];

    // Chirp amplitude: depth level = ampl * (100 - depth) / 100, depth capped at 100%
    logic [15:0] a_full, a_low, a_from, a_to, as, a_now;
    logic [31:0] a_low_w, a_mul;
    assign a_full  = ampl_r[15:0];
    assign a_low_w = (32'(a_full) * 32'(100 - (am_depth_r > cms_pkg::CHIRP_DEPTH_MAX ?
                      cms_pkg::CHIRP_DEPTH_MAX : am_depth_r))) / 32'd100;
    assign a_low   = a_low_w[15:0];
    assign a_from  = ctrl_r[cms_pkg::CTRL_AM_DOWN] ? a_full : a_low;
    assign a_to    = ctrl_r[cms_pkg::CTRL_AM_DOWN] ? a_low : a_full;
    assign as      = shape_step(frac, ctrl_r[cms_pkg::CTRL_AM_LOG]);
    assign a_mul   = 32'(a_to > a_from ? a_to - a_from : a_from - a_to) * 32'(as);
    assign a_now   = a_to > a_from ? a_from + a_mul[31:16] : a_from - a_mul[31:16];

    // AM envelope generator
    logic [31:0] env_ph_r, env_inc;
    logic [47:0] env_inc_w;
    logic [15:0] env_val, am_ampl;
    logic [32:0] am_prod;
    assign env_inc_w = 48'(am_freq_r) * 48'(cms_pkg::ENV_K_NUM);
    assign env_inc   = env_inc_w[39:8];
    always_ff @(posedge clk_i) begin
        if (rst_i || mode != cms_pkg::MOD_AM) env_ph_r <= '0;
        else if (ce_i) env_ph_r <= env_ph_r + env_inc;
    end
    always_comb begin
        unique case (cms_pkg::cms_shape_t'(ctrl_r[cms_pkg::CTRL_ENV_LSB +: 2]))
            cms_pkg::SHP_SINE,
            cms_pkg::SHP_TRI:  env_val = env_ph_r[31] ? ~{env_ph_r[30:16], 1'b0}
                                                      : {env_ph_r[30:16], 1'b0};
            cms_pkg::SHP_SQR:  env_val = env_ph_r[31] ? 16'h0000 : 16'hffff;
            cms_pkg::SHP_RAMP: env_val = env_ph_r[31:16];
        endcase
    end
    // Gain = 1 + depth*(env-0.5), depth in percent up to 200%
    logic signed [31:0] am_gain;
    assign am_gain = 32'sh0001_0000 + ((($signed({16'h0, env_val}) - 32'sh8000) *
                     $signed({24'h0, am_depth_r})) / 32'sd100);
    assign am_prod = 33'(a_full) * 33'(am_gain < 0 ? 32'h0 : am_gain[31:0]);
    // Saturate instead of wrapping above full scale
    assign am_ampl = am_prod[32] ? 16'hffff : am_prod[31:16];

    // Marker detection
    logic [31:0] f_prev_r;
    logic        sw_cross;
    always_ff @(posedge clk_i) begin
        if (rst_i) f_prev_r <= '0;
        else if (ce_i) f_prev_r <= f_now;
    end
    assign sw_cross = (f_prev_r < sw_mark_r && f_now >= sw_mark_r) ||
                      (f_prev_r > sw_mark_r && f_now <= sw_mark_r);

    // Output registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            synth_o <= '0;
            sync_o  <= 1'b0;
        end else if (ce_i) begin
            synth_o.carrier_shape <= ctrl_r[cms_pkg::CTRL_SHAPE_LSB +: 2];
            synth_o.mode          <= mode;
            sync_o                <= 1'b0;
            unique case (mode)
                cms_pkg::MOD_FHOP: begin
                    synth_o.freq <= hop_freq_mem[hop_pos_r];
                    synth_o.ampl <= a_full;
                    synth_o.carrier_shape <= 2'(cms_pkg::SHP_SINE);
                    sync_o <= hop_cnt_r == 32'h0 && hop_pos_r == hop_mark_r;
                end
                cms_pkg::MOD_SWEEP: begin
                    synth_o.freq <= {16'h0, f_now};
                    synth_o.ampl <= a_full;
                    sync_o <= sw_cross && t_r != 32'h0;
                end
                cms_pkg::MOD_CHIRP: begin
                    synth_o.freq <= {16'h0, f_now};
                    synth_o.ampl <= per_r < sw_len ? a_now : 16'h0;
                    sync_o <= per_r == 32'h0;
                end
                cms_pkg::MOD_AM: begin
                    synth_o.freq <= {16'h0, cw_freq_r};
                    synth_o.ampl <= am_ampl;
                end
                default: begin
                    synth_o.freq <= {16'h0, cw_freq_r};
                    synth_o.ampl <= a_full;
                end
            endcase
        end
    end

    // Bus answer
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        unique case (a)
            cms_pkg::OFF_CTRL:     return ctrl_r;
            cms_pkg::OFF_CW_FREQ:  return cw_freq_r;
            cms_pkg::OFF_AMPL:     return ampl_r;
            cms_pkg::OFF_DWELL:    return dwell_r;
            cms_pkg::OFF_HOP_LEN:  return 32'(hop_len_r);
            cms_pkg::OFF_HOP_MARK: return 32'(hop_mark_r);
            cms_pkg::OFF_SW_START: return sw_start_r;
            cms_pkg::OFF_SW_STOP:  return sw_stop_r;
            cms_pkg::OFF_SW_TIME:  return sw_time_r;
            cms_pkg::OFF_SW_MARK:  return sw_mark_r;
            cms_pkg::OFF_CH_PRI:   return ch_pri_r;
            cms_pkg::OFF_AM_DEPTH: return 32'(am_depth_r);
            cms_pkg::OFF_AM_FREQ:  return am_freq_r;
            cms_pkg::OFF_STATUS:   return {16'h0, 8'(hop_pos_r), 8'(frac[15:8])};
            cms_pkg::OFF_HOP_IDX:  return {tbl_hi_r, 16'(tbl_idx_r)};
            default:               return 32'h0;
        endcase
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_mux(wb_adr_i) : 32'h0;
        end
    end

    // Assertions
    property p_hop_hold;
        @(posedge clk_i) disable iff (rst_i)
        (mode == cms_pkg::MOD_FHOP && ce_i && !hop_end && !wr) |=> $stable(hop_pos_r);
    endproperty
    a_hop_hold: assert property (p_hop_hold) else $error("hop step moved mid-dwell");

    property p_hop_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (mode == cms_pkg::MOD_FHOP && ce_i && hop_end && hop_pos_r >= hop_len_r && !wr)
        |=> hop_pos_r == '0;
    endproperty
    a_hop_wrap: assert property (p_hop_wrap) else $error("hop did not wrap");

    property p_sweep_restart;
        @(posedge clk_i) disable iff (rst_i)
        (mode == cms_pkg::MOD_SWEEP && ce_i && t_r + 32'h1 >= sw_time_r && !wr) |=> t_r == 0;
    endproperty
    a_sweep_restart: assert property (p_sweep_restart) else $error("sweep no restart");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

    property p_mode_follow;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> synth_o.mode == $past(mode);
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode not applied");

    property p_hop_mark;
        @(posedge clk_i) disable iff (rst_i)
        (mode == cms_pkg::MOD_FHOP && ce_i && hop_cnt_r == 32'h0 &&
         hop_pos_r == hop_mark_r) |=> sync_o;
    endproperty
    a_hop_mark: assert property (p_hop_mark) else $error("hop marker missing");

    // Chirp period wraps, next enabled cycle starts a chirp and marks it
    sequence s_chirp_wrap;
        mode == cms_pkg::MOD_CHIRP && ce_i && !wr && per_r + 32'h1 >= ch_pri_r ##1 ce_i;
    endsequence
    sequence s_chirp_mark;
        per_r == 32'h0 ##1 sync_o;
    endsequence
    property p_chirp_mark;
        @(posedge clk_i) disable iff (rst_i)
        s_chirp_wrap |-> s_chirp_mark;
    endproperty
    a_chirp_mark: assert property (p_chirp_mark) else $error("chirp start unmarked");
endmodule
`default_nettype wire

// File: cms_synth_model.sv
// Synthesis datapath model: takes commands and counts marker pulses
`timescale 1ns/1ns
`default_nettype none
module cms_synth_model (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire cms_pkg::cms_synth_t synth_i,
    input  wire logic                sync_i,
    output logic      [31:0]         sync_cnt_o
);
    // Marker pulse counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_cnt_o <= 32'h0;
        end else if (sync_i) begin
            sync_cnt_o <= sync_cnt_o + 32'h1;
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the modulation sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                clk_i, rst_i, cyc, stb, we, ack, sync, bad, ce;
    logic [7:0]          adr;
    logic [3:0]          sel;
    logic [31:0]         wdat, rdat, q, scnt;
    logic [47:0]         hf[3], lo, hi;
    logic [31:0]         hd[3];
    cms_pkg::cms_synth_t syn;
    int                  error_cnt, checks;

    cms_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .synth_o(syn), .sync_o(sync));
    cms_synth_model mdl (.clk_i(clk_i), .rst_i(rst_i), .synth_i(syn), .sync_i(sync),
        .sync_cnt_o(scnt));

    task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Bounded wait ran out: count it and close the run
    task automatic tmo(input int c, input int lim);
        if (c >= lim) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    // Classic single Wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    task automatic hop(input logic vd);
        logic [47:0] f;
        int i, c, k, s0;
        wb(1'b1, cms_pkg::OFF_CTRL, (32'(vd) << cms_pkg::CTRL_DWELL_VAR) | 32'h3);
        f = syn.freq;
        for (c = 0; syn.freq === f && c < 500; c++) @(posedge clk_i);
        tmo(c, 500);
        k = 0;
        for (i = 0; i < 3; i++) if (syn.freq === hf[i]) k = i;
        for (i = 0; i < 7; i++) begin
            chk("hop freq", syn.freq, hf[k]);
            f = syn.freq;
            for (c = 0; syn.freq === f && c < 500; c++) begin
                if (c == 10 && i == 0) s0 = scnt;
                if (c == 10 && i == 6) chk("hop sync", scnt - s0, 2);
                @(posedge clk_i);
            end
            if (i < 6) chk("hop dwell", c, vd ? hd[k] : 32'd20);
            tmo(c, 500);
            k = (k + 1) % 3;
        end
        $display("hop test done, variable dwell %0d", vd);
    endtask

    task automatic sweep(input logic lg, input logic dn);
        logic [47:0] a, p;
        int n, c, r, s0;
        a = dn ? hi : lo;
        wb(1'b1, cms_pkg::OFF_CTRL, (32'(lg) << 9) | (32'(dn) << 10) | 32'h4);
        p = 48'h0;
        c = 0;
        r = 0;
        bad = 1'b0;
        for (n = 0; n < 1000 && r < 3; n++) begin
            @(posedge clk_i);
            if (syn.freq === a && p !== a) begin
                if (r > 0) chk("sweep time", c, 200);
                if (r == 2) chk("sweep sync", scnt - s0, 1);
                s0 = scnt;
                r++;
                c = 0;
            end else if (r > 0) begin
                bad |= dn ? (syn.freq > p) : (syn.freq < p);
                bad |= syn.freq > hi || syn.freq < lo;
            end
            c++;
            p = syn.freq;
        end
        chk("sweep restarts", r, 3);
        chk("sweep direction", bad, 0);
        tmo(3 - r, 1);
        $display("sweep test done, log %0d down %0d", lg, dn);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        int i, c, n, s0, z;
        logic [15:0] amp, p;
        cms_pkg::cms_synth_t s1;
        {rst_i, cyc, stb, we, adr, sel, wdat, q, bad} = {1'b1, 80'h0};
        ce = 1'b1;
        error_cnt = 0;
        checks = 0;
        void'($urandom(32'hf01c));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset outputs", {syn, sync, ack}, 0);
        wb(1'b0, 8'hfc, 32'h0);
        chk("unmapped read", q, 0);
        for (i = 0; i < 9; i++) begin
            c = $urandom % 3;
            wb(1'b1, cms_pkg::OFF_CTRL, 32'(i) | (32'(c) << cms_pkg::CTRL_SHAPE_LSB));
            @(posedge clk_i);
            chk("mode", syn.mode, i);
            chk("shape", syn.carrier_shape, (i == 3) ? 0 : c);
        end
        $display("mode test done");
        for (i = 0; i < 3; i++) begin
            hf[i] = {16'($urandom), $urandom};
            hf[i][1:0] = 2'(i);
            hd[i] = 12 + $urandom % 29;
            wb(1'b1, cms_pkg::OFF_HOP_IDX, {hf[i][47:32], 16'(i)});
            wb(1'b1, cms_pkg::OFF_HOP_FREQ, hf[i][31:0]);
            wb(1'b1, cms_pkg::OFF_HOP_DWELL, hd[i]);
        end
        wb(1'b1, cms_pkg::OFF_HOP_LEN, 32'h2);
        wb(1'b1, cms_pkg::OFF_HOP_MARK, 32'h1);
        wb(1'b1, cms_pkg::OFF_DWELL, 32'd20);
        hop(1'b0);
        hop(1'b1);
        lo = 48'($urandom % 32'h4000_0000);
        hi = lo + 48'h8000_0000;
        wb(1'b1, cms_pkg::OFF_SW_START, lo[31:0]);
        wb(1'b1, cms_pkg::OFF_SW_STOP, hi[31:0]);
        wb(1'b1, cms_pkg::OFF_SW_MARK, lo[31:0] + 32'h4000_0000);
        wb(1'b1, cms_pkg::OFF_SW_TIME, 32'd200);
        for (i = 0; i < 4; i++) sweep(i[0], i[1]);
        amp = 16'($urandom) | 16'h8000;
        wb(1'b1, cms_pkg::OFF_AMPL, 32'(amp));
        wb(1'b1, cms_pkg::OFF_AM_DEPTH, 32'd100);
        wb(1'b1, cms_pkg::OFF_CH_PRI, 32'd300);
        wb(1'b1, cms_pkg::OFF_CTRL, 32'h5);
        @(posedge clk_i);
        s0 = scnt;
        c = 0;
        z = 0;
        bad = 1'b0;
        for (n = 0; n < 2000 && scnt - s0 < 3; n++) begin
            @(posedge clk_i);
            if (scnt - s0 == 1) begin
                c++;
                z += int'(syn.ampl === 16'h0);
                if (sync === 1'b1) chk("chirp start ampl", syn.ampl, 0);
            end
            bad |= syn.ampl > amp;
        end
        chk("chirp period", c, 300);
        chk("chirp gap", z, 300 - 200 + 1);
        chk("chirp amplitude", bad, 0);
        tmo(3 - (scnt - s0), 1);
        $display("chirp test done");
        wb(1'b1, cms_pkg::OFF_AM_DEPTH, 32'hfa);
        wb(1'b0, cms_pkg::OFF_AM_DEPTH, 32'h0);
        chk("am depth clamp", q, cms_pkg::AM_DEPTH_MAX);
        wb(1'b1, cms_pkg::OFF_AM_FREQ, 32'd50);
        wb(1'b0, cms_pkg::OFF_AM_FREQ, 32'h0);
        chk("am freq low", q, cms_pkg::AM_FMIN_HZ);
        wb(1'b1, cms_pkg::OFF_AM_FREQ, 32'd2000000);
        wb(1'b0, cms_pkg::OFF_AM_FREQ, 32'h0);
        chk("am freq high", q, cms_pkg::AM_FMAX_HZ);
        wb(1'b1, cms_pkg::OFF_AM_DEPTH, 32'd100);
        wb(1'b1, cms_pkg::OFF_AM_FREQ, 32'd10000);
        for (i = 0; i < 4; i++) begin
            wb(1'b1, cms_pkg::OFF_CTRL, 32'h6 | (32'(i) << cms_pkg::CTRL_ENV_LSB));
            p = syn.ampl;
            c = 0;
            repeat (2100) begin
                @(posedge clk_i);
                c += int'(syn.ampl !== p);
                p = syn.ampl;
            end
            chk("am envelope", c > 1, 1);
        end
        $display("am test done");
        ce <= 1'b0;
        @(posedge clk_i);
        s1 = syn;
        repeat (40) @(posedge clk_i);
        chk("clock enable freeze", syn, s1);
        ce <= 1'b1;
        $display("freeze test done");
        end_of_test();
    end
endmodule
`default_nettype wire
